// *** design/cms_core_regs.vh ***
// constants for the move, multiply and or execution slice
`ifndef CMS_CORE_REGS_VH
`define CMS_CORE_REGS_VH

// opcodes
`define CMS_OP_NOP 8'h00
`define CMS_OP_MOV_DIR_IND 7'h43
`define CMS_OP_MOV_DIR_IMM 8'h75
`define CMS_OP_MOV_IND_ACC 7'h7B
`define CMS_OP_MOV_IND_DIR 7'h53
`define CMS_OP_MOV_IND_IMM 7'h3B
`define CMS_OP_MOV_C_BIT 8'hA2
`define CMS_OP_MOV_BIT_C 8'h92
`define CMS_OP_MOV_DATA_POINTER 8'h90
`define CMS_OP_CODE_BYTE_LOAD_DATA_POINTER 8'h93
`define CMS_OP_CODE_BYTE_LOAD_PC 8'h83
`define CMS_OP_EXTERNAL_DATA_MOVE_RD_IND 7'h71
`define CMS_OP_EXTERNAL_DATA_MOVE_WR_IND 7'h79
`define CMS_OP_EXTERNAL_DATA_MOVE_RD_DP 8'hE0
`define CMS_OP_EXTERNAL_DATA_MOVE_WR_DP 8'hF0
`define CMS_OP_MUL 8'hA4
`define CMS_OP_ORL_A_REG 5'h09
`define CMS_OP_ORL_A_DIR 8'h45
`define CMS_OP_ORL_A_IND 7'h23
`define CMS_OP_ORL_A_IMM 8'h44
`define CMS_OP_ORL_DIR_A 8'h42
`define CMS_OP_ORL_DIR_IMM 8'h43

// special function register addresses
`define CMS_SFR_LOW_PORT 8'h80
`define CMS_SFR_DPL 8'h82
`define CMS_SFR_DPH 8'h83
`define CMS_SFR_HIGH_PORT 8'hA0
`define CMS_SFR_PSW 8'hD0
`define CMS_SFR_ACC 8'hE0
`define CMS_SFR_B 8'hF0

// status word fields
`define CMS_PSW_CY 7
`define CMS_PSW_OV 2
`define CMS_PSW_BANK_HI 4
`define CMS_PSW_BANK_LO 3

// reset values
`define CMS_RST_PORT 8'hFF
`define CMS_RST_BYTE 8'h00

// clock slots inside one instruction
`define CMS_T_OPCODE 8'h00
`define CMS_T_BYTE1 8'h01
`define CMS_T_BYTE2 8'h02
`define CMS_T_EXEC 8'h03
`define CMS_T_ALE_OFF 8'h04
`define CMS_T_STB_ON 8'h05
`define CMS_T_CAPTURE 8'h0A
`define CMS_MC_CLKS 6
`endif

// *** design/cms_mul8.v ***
// unsigned 8x8 multiplier with overflow detect
`timescale 1ns/100ps
module cms_mul8 #(
  parameter W = 8
) (
  input wire [W-1:0] i_a,
  input wire [W-1:0] i_b,
  output wire [W-1:0] o_lo,
  output wire [W-1:0] o_hi,
  output wire o_ovf
);
  wire [2*W-1:0] prod;
  assign prod = i_a * i_b;
  assign o_lo = prod[W-1:0];
  assign o_hi = prod[2*W-1:W];
  // any high bit set means the product passed 255
  assign o_ovf = |prod[2*W-1:W]; // [RQ14]
endmodule // cms_mul8

// *** design/cms_core.v ***
// execution slice: byte/bit moves, pointer load, code and external moves, multiply, or
// Operation
// [RQ1] move @index to direct: opcode 1000011i, two bytes, two machine cycles
// [RQ2] move immediate to direct: 01110101, address then data, three bytes, two cycles
// [RQ3] store accumulator at @index: 1111011i, one byte, one cycle
// [RQ4] move direct to @index: 1010011i, two bytes, two cycles
// [RQ5] move immediate to @index: 0111011i, two bytes, one cycle
// [RQ6] bit moves use carry plus an addressable bit; A2 one cycle, 92 two
// [RQ7] pointer load 10010000: first operand high half, second low, flags kept
// [RQ8] code load address is accumulator plus 16-bit base, full carry, flags kept
// [RQ9] program counter base: advance past instruction first; one byte, two cycles
// [RQ10] data pointer base code load leaves data pointer untouched
// [RQ11] external move by index: 8-bit address muxed on low port bus, two cycles
// [RQ12] external move by pointer: high byte on high bus, low byte muxed
// [RQ13] high port latch keeps its contents while pins show pointer high byte
// [RQ14] multiply: low byte to accumulator, high to multiplier reg, overflow, carry cleared
// [RQ15] no operation only advances the program counter
// [RQ16] logical or stores bitwise or in destination, flags unchanged, six source forms
// [RQ17] or on an output port reads the output latch, not the pins
// [RQ18] or with bank register: 01001rrr, one byte
// [RQ19] moves copy source to destination, source and other state untouched
// [RQ20] external accesses drive address latch, read and write strobes
`timescale 1ns/100ps
`include "cms_core_regs.vh"
module cms_core #(
  parameter MC_CLKS = `CMS_MC_CLKS,
  parameter RAM_DEPTH = 256
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  output wire [15:0] o_code_addr,
  input wire [7:0] i_code_data,
  output wire [7:0] o_low_port_bus,
  output wire o_low_port_oe,
  input wire [7:0] i_low_port_bus,
  output wire [7:0] o_high_port_bus,
  output wire o_ale,
  output wire o_rd_n,
  output wire o_wr_n,
  output wire o_instr_done,
  output wire o_illegal,
  output wire [15:0] o_program_counter,
  output wire [7:0] o_acc,
  output wire [7:0] o_mul_reg,
  output wire [7:0] o_psw,
  output wire [15:0] o_data_pointer
);
  localparam [7:0] MC8 = MC_CLKS[7:0];

  reg [7:0] ram [0:RAM_DEPTH-1];
  reg [15:0] pc_ff;
  reg [7:0] acc_ff, b_ff, psw_ff, dpl_ff, dph_ff, lo_latch_ff, hi_latch_ff;
  reg [7:0] op_ff, b1_ff, b2_ff, t_ff;
  reg ale_ff, rd_ff, wr_ff, lo_oe_ff, hi_dp_ff, done_ff, ill_ff;
  reg [7:0] lo_out_ff;
  reg [7:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;

  // decode: {legal, bytes[1:0], cycles[2:0]}
  function [5:0] decode;
    input [7:0] op;
    begin
      if (op[7:1] == `CMS_OP_MOV_DIR_IND || op[7:1] == `CMS_OP_MOV_IND_DIR)
        decode = 6'h32; // [RQ1] [RQ4]
      else if (op[7:1] == `CMS_OP_MOV_IND_ACC)
        decode = 6'h29; // [RQ3]
      else if (op[7:1] == `CMS_OP_MOV_IND_IMM)
        decode = 6'h31; // [RQ5]
      else if (op[7:1] == `CMS_OP_EXTERNAL_DATA_MOVE_RD_IND || op[7:1] == `CMS_OP_EXTERNAL_DATA_MOVE_WR_IND)
        decode = 6'h2A; // [RQ11]
      else if (op[7:1] == `CMS_OP_ORL_A_IND || op[7:3] == `CMS_OP_ORL_A_REG)
        decode = 6'h29; // [RQ18]
      else begin
        case (op)
          `CMS_OP_NOP: decode = 6'h29; // [RQ15]
          `CMS_OP_MOV_DIR_IMM: decode = 6'h3A; // [RQ2]
          `CMS_OP_MOV_C_BIT: decode = 6'h31; // [RQ6]
          `CMS_OP_MOV_BIT_C: decode = 6'h32; // [RQ6]
          `CMS_OP_MOV_DATA_POINTER: decode = 6'h3A;
          `CMS_OP_CODE_BYTE_LOAD_DATA_POINTER: decode = 6'h2A;
          `CMS_OP_CODE_BYTE_LOAD_PC: decode = 6'h2A; // [RQ9]
          `CMS_OP_EXTERNAL_DATA_MOVE_RD_DP: decode = 6'h2A; // [RQ12]
          `CMS_OP_EXTERNAL_DATA_MOVE_WR_DP: decode = 6'h2A;
          `CMS_OP_MUL: decode = 6'h2C;
          `CMS_OP_ORL_A_DIR: decode = 6'h31;
          `CMS_OP_ORL_A_IMM: decode = 6'h31;
          `CMS_OP_ORL_DIR_A: decode = 6'h31;
          `CMS_OP_ORL_DIR_IMM: decode = 6'h3A;
          default: decode = 6'h09;
        endcase
      end
    end
  endfunction

  // direct-space read; rmw selects the low port latch over its pins; the high port always reads its latch
  function [7:0] rd_dir;
    input [7:0] a;
    input rmw;
    begin
      if (!a[7])
        rd_dir = ram[a];
      else begin
        case (a)
          `CMS_SFR_LOW_PORT: rd_dir = rmw ? lo_latch_ff : pin_ff; // [RQ17]
          `CMS_SFR_HIGH_PORT: rd_dir = hi_latch_ff;
          `CMS_SFR_DPL: rd_dir = dpl_ff;
          `CMS_SFR_DPH: rd_dir = dph_ff;
          `CMS_SFR_PSW: rd_dir = psw_ff;
          `CMS_SFR_ACC: rd_dir = acc_ff;
          `CMS_SFR_B: rd_dir = b_ff;
          default: rd_dir = `CMS_RST_BYTE;
        endcase
      end
    end
  endfunction

  wire [5:0] dec = decode(op_ff);
  wire [1:0] nbytes = dec[4:3];
  wire [7:0] t_last = {5'h00, dec[2:0]} * MC8 - 8'h01;
  wire [1:0] bank = psw_ff[`CMS_PSW_BANK_HI:`CMS_PSW_BANK_LO];
  wire [7:0] ri_addr = ram[{3'b000, bank, 2'b00, op_ff[0]}];
  wire [7:0] ri_data = ram[ri_addr];
  wire [7:0] rn_data = ram[{3'b000, bank, op_ff[2:0]}];
  wire [7:0] bit_byte = b1_ff[7] ? {b1_ff[7:3], 3'b000} : {4'h2, b1_ff[6:3]};
  wire [7:0] bit_val = rd_dir(bit_byte, 1'b0);
  wire [7:0] bit_latch = rd_dir(bit_byte, 1'b1);
  wire is_x_ind = (op_ff[7:1] == `CMS_OP_EXTERNAL_DATA_MOVE_RD_IND) || (op_ff[7:1] == `CMS_OP_EXTERNAL_DATA_MOVE_WR_IND);
  wire is_x_dp = (op_ff == `CMS_OP_EXTERNAL_DATA_MOVE_RD_DP) || (op_ff == `CMS_OP_EXTERNAL_DATA_MOVE_WR_DP);
  wire is_x_wr = op_ff[4];
  wire is_code_byte_load = (op_ff == `CMS_OP_CODE_BYTE_LOAD_DATA_POINTER) || (op_ff == `CMS_OP_CODE_BYTE_LOAD_PC);
  // pc already sits past this one-byte opcode when the sum is formed
  wire [15:0] code_byte_load_base = (op_ff == `CMS_OP_CODE_BYTE_LOAD_PC) ? pc_ff : {dph_ff, dpl_ff}; // [RQ9] [RQ10]
  wire [15:0] code_byte_load_addr = code_byte_load_base + {8'h00, acc_ff}; // [RQ8]
  wire exec = (t_ff == `CMS_T_EXEC);
  wire [7:0] mul_lo, mul_hi;
  wire mul_ovf;

  cms_mul8 #(
    .W(8)
  ) u_mul (
    .i_a(acc_ff),
    .i_b(b_ff),
    .o_lo(mul_lo),
    .o_hi(mul_hi),
    .o_ovf(mul_ovf)
  );

  // execute-slot write requests
  reg dw_en, iw_en, acc_en, b_en, cy_en, ov_en, dp_en;
  reg [7:0] dw_a, dw_d, iw_d, acc_d;
  reg cy_d, ov_d;
  always @* begin
    dw_en = 1'b0;
    iw_en = 1'b0;
    acc_en = 1'b0;
    b_en = 1'b0;
    cy_en = 1'b0;
    ov_en = 1'b0;
    dp_en = 1'b0;
    dw_a = b1_ff;
    dw_d = `CMS_RST_BYTE;
    iw_d = `CMS_RST_BYTE;
    acc_d = `CMS_RST_BYTE;
    cy_d = 1'b0;
    ov_d = 1'b0;
    if (op_ff[7:1] == `CMS_OP_MOV_DIR_IND) begin
      dw_en = 1'b1;
      dw_d = ri_data; // [RQ1] [RQ19]
    end else if (op_ff[7:1] == `CMS_OP_MOV_IND_ACC) begin
      iw_en = 1'b1;
      iw_d = acc_ff; // [RQ3]
    end else if (op_ff[7:1] == `CMS_OP_MOV_IND_DIR) begin
      iw_en = 1'b1;
      iw_d = rd_dir(b1_ff, 1'b0); // [RQ4]
    end else if (op_ff[7:1] == `CMS_OP_MOV_IND_IMM) begin
      iw_en = 1'b1;
      iw_d = b1_ff; // [RQ5]
    end else if (op_ff[7:1] == `CMS_OP_ORL_A_IND) begin
      acc_en = 1'b1;
      acc_d = acc_ff | ri_data; // [RQ16]
    end else if (op_ff[7:3] == `CMS_OP_ORL_A_REG) begin
      acc_en = 1'b1;
      acc_d = acc_ff | rn_data; // [RQ18]
    end else begin
      case (op_ff)
        `CMS_OP_MOV_DIR_IMM: begin
          dw_en = 1'b1;
          dw_d = b2_ff; // [RQ2]
        end
        `CMS_OP_MOV_C_BIT: begin
          cy_en = 1'b1;
          cy_d = bit_val[b1_ff[2:0]]; // [RQ6]
        end
        `CMS_OP_MOV_BIT_C: begin
          dw_en = 1'b1;
          dw_a = bit_byte;
          dw_d = bit_latch;
          dw_d[b1_ff[2:0]] = psw_ff[`CMS_PSW_CY]; // [RQ6] [RQ19]
        end
        `CMS_OP_MOV_DATA_POINTER: dp_en = 1'b1; // [RQ7]
        `CMS_OP_CODE_BYTE_LOAD_DATA_POINTER, `CMS_OP_CODE_BYTE_LOAD_PC: begin
          acc_en = 1'b1;
          acc_d = i_code_data; // [RQ8]
        end
        `CMS_OP_MUL: begin
          acc_en = 1'b1;
          acc_d = mul_lo;
          b_en = 1'b1;
          ov_en = 1'b1;
          ov_d = mul_ovf;
          cy_en = 1'b1; // [RQ14]
        end
        `CMS_OP_ORL_A_DIR: begin
          acc_en = 1'b1;
          acc_d = acc_ff | rd_dir(b1_ff, 1'b0); // [RQ16]
        end
        `CMS_OP_ORL_A_IMM: begin
          acc_en = 1'b1;
          acc_d = acc_ff | b1_ff; // [RQ16]
        end
        `CMS_OP_ORL_DIR_A: begin
          dw_en = 1'b1;
          dw_d = rd_dir(b1_ff, 1'b1) | acc_ff; // [RQ16] [RQ17]
        end
        `CMS_OP_ORL_DIR_IMM: begin
          dw_en = 1'b1;
          dw_d = rd_dir(b1_ff, 1'b1) | b2_ff; // [RQ16] [RQ17]
        end
        default: dw_en = 1'b0;
      endcase
    end
  end

  // pin sampler; the filtered value moves only when stages two and three agree
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sync1_ff <= `CMS_RST_BYTE;
      sync2_ff <= `CMS_RST_BYTE;
      sync3_ff <= `CMS_RST_BYTE;
      pin_ff <= `CMS_RST_BYTE;
    end else begin
      sync1_ff <= i_low_port_bus;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff)
        pin_ff <= sync3_ff;
    end
  end

  // ram is left unreset; software owns its contents
  always @(posedge i_core_clk) begin
    if (exec && iw_en)
      ram[ri_addr] <= iw_d;
    else if (exec && dw_en && !dw_a[7])
      ram[dw_a] <= dw_d;
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pc_ff <= 16'h0000;
      acc_ff <= `CMS_RST_BYTE;
      b_ff <= `CMS_RST_BYTE;
      psw_ff <= `CMS_RST_BYTE;
      dpl_ff <= `CMS_RST_BYTE;
      dph_ff <= `CMS_RST_BYTE;
      lo_latch_ff <= `CMS_RST_PORT;
      hi_latch_ff <= `CMS_RST_PORT;
      op_ff <= `CMS_OP_NOP;
      b1_ff <= `CMS_RST_BYTE;
      b2_ff <= `CMS_RST_BYTE;
      t_ff <= `CMS_T_OPCODE;
      ale_ff <= 1'b0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      lo_oe_ff <= 1'b1;
      lo_out_ff <= `CMS_RST_PORT;
      hi_dp_ff <= 1'b0;
      done_ff <= 1'b0;
      ill_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      ill_ff <= 1'b0;
      t_ff <= t_ff + 8'h01;
      // operand fetch, one code byte per clock
      if (t_ff == `CMS_T_OPCODE) begin
        op_ff <= i_code_data;
        pc_ff <= pc_ff + 16'h0001; // [RQ15]
      end
      if (t_ff == `CMS_T_BYTE1 && nbytes != 2'b01) begin
        b1_ff <= i_code_data;
        pc_ff <= pc_ff + 16'h0001;
      end
      if (t_ff == `CMS_T_BYTE2 && nbytes == 2'b11) begin
        b2_ff <= i_code_data;
        pc_ff <= pc_ff + 16'h0001;
      end
      if (exec) begin
        ill_ff <= ~dec[5];
        if (acc_en)
          acc_ff <= acc_d;
        if (b_en)
          b_ff <= mul_hi; // [RQ14]
        if (cy_en)
          psw_ff[`CMS_PSW_CY] <= cy_d;
        if (ov_en)
          psw_ff[`CMS_PSW_OV] <= ov_d;
        if (dp_en) begin
          dph_ff <= b1_ff; // [RQ7]
          dpl_ff <= b2_ff;
        end
        if (dw_en && dw_a[7]) begin
          case (dw_a)
            `CMS_SFR_LOW_PORT: lo_latch_ff <= dw_d;
            `CMS_SFR_HIGH_PORT: hi_latch_ff <= dw_d;
            `CMS_SFR_DPL: dpl_ff <= dw_d;
            `CMS_SFR_DPH: dph_ff <= dw_d;
            `CMS_SFR_PSW: psw_ff <= dw_d;
            `CMS_SFR_ACC: acc_ff <= dw_d;
            `CMS_SFR_B: b_ff <= dw_d;
            default: ill_ff <= 1'b0;
          endcase
        end
        // external cycle: address phase with latch enable
        if (is_x_ind || is_x_dp) begin
          ale_ff <= 1'b1; // [RQ20]
          lo_oe_ff <= 1'b1;
          lo_out_ff <= is_x_dp ? dpl_ff : ri_addr; // [RQ11] [RQ12]
          hi_dp_ff <= is_x_dp; // [RQ12]
        end
      end
      if ((is_x_ind || is_x_dp) && t_ff == `CMS_T_ALE_OFF)
        ale_ff <= 1'b0;
      if ((is_x_ind || is_x_dp) && t_ff == `CMS_T_STB_ON) begin
        // bus is released for reads so memory can drive it
        rd_ff <= ~is_x_wr; // [RQ20]
        wr_ff <= is_x_wr;
        lo_oe_ff <= is_x_wr;
        lo_out_ff <= acc_ff;
      end
      if ((is_x_ind || is_x_dp) && t_ff == `CMS_T_CAPTURE) begin
        if (!is_x_wr)
          acc_ff <= pin_ff; // [RQ20]
        rd_ff <= 1'b0;
        wr_ff <= 1'b0;
        lo_oe_ff <= 1'b1;
        lo_out_ff <= lo_latch_ff;
        hi_dp_ff <= 1'b0;
      end
      if (t_ff == t_last) begin
        t_ff <= `CMS_T_OPCODE;
        done_ff <= 1'b1;
      end
      if (!(is_x_ind || is_x_dp) && t_ff != `CMS_T_OPCODE && !rd_ff && !wr_ff)
        lo_out_ff <= lo_latch_ff;
    end
  end

  // the code address leaves the pc only for the table read slot
  assign o_code_addr = (exec && is_code_byte_load) ? code_byte_load_addr : pc_ff; // [RQ8]
  assign o_low_port_bus = lo_out_ff;
  assign o_low_port_oe = lo_oe_ff;
  // latch stays put while the pins carry the pointer high byte
  assign o_high_port_bus = hi_dp_ff ? dph_ff : hi_latch_ff; // [RQ13]
  assign o_ale = ale_ff;
  assign o_rd_n = ~rd_ff;
  assign o_wr_n = ~wr_ff;
  assign o_instr_done = done_ff;
  assign o_illegal = ill_ff;
  assign o_program_counter = pc_ff;
  assign o_acc = acc_ff;
  assign o_mul_reg = b_ff;
  assign o_psw = psw_ff;
  assign o_data_pointer = {dph_ff, dpl_ff};
endmodule // cms_core

// *** dv/cms_core_assertions.sv ***
// concurrent checks on the core's external bus strobes and instruction length
`timescale 1ns/100ps
module cms_core_assertions #(
  parameter MC_CLKS = 6
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_low_port_bus,
  input wire logic [7:0] o_low_port_bus,
  input wire logic o_low_port_oe,
  input wire logic [7:0] o_high_port_bus,
  input wire logic o_ale,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_instr_done,
  input wire logic [7:0] o_acc
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] len_ff;
  logic seen_ff;
  // clocks since the last done pulse; the first instruction is skipped
  always @(posedge i_core_clk) begin
    if (i_sys_rst || o_instr_done)
      len_ff <= 8'h00;
    else
      len_ff <= len_ff + 8'h01;
    if (i_sys_rst)
      seen_ff <= 1'b0;
    else if (o_instr_done)
      seen_ff <= 1'b1;
  end
  sequence ale_pulse;
    o_ale ##1 !o_ale;
  endsequence
  sequence strobe_low;
    (o_rd_n ^ o_wr_n)[*5] ##1 (o_rd_n && o_wr_n);
  endsequence
  a_ale_one_clock: assert property ($rose(o_ale) |-> ale_pulse)
    else $error("address latch pulse not one clock");
  a_strobe_window: assert property ($rose(o_ale) |-> ##2 strobe_low)
    else $error("strobe window wrong after address latch");
  a_read_release: assert property (!o_rd_n |-> !o_low_port_oe)
    else $error("low port driven during read strobe");
  a_write_data: assert property (!o_wr_n |-> o_low_port_oe && o_low_port_bus == o_acc)
    else $error("write data not accumulator");
  a_high_steady: assert property ((!o_rd_n || !o_wr_n) && $past(!o_rd_n || !o_wr_n)
    |-> $stable(o_high_port_bus))
    else $error("high port moved during strobe");
  a_read_capture: assert property ($rose(o_rd_n) |-> o_acc == $past(i_low_port_bus))
    else $error("read data not captured");
  a_instr_length: assert property (o_instr_done && seen_ff |-> (len_ff + 8'h01 == MC_CLKS)
    || (len_ff + 8'h01 == 2 * MC_CLKS) || (len_ff + 8'h01 == 4 * MC_CLKS))
    else $error("instruction length not whole machine cycles");
  a_rd_wr_excl: assert property (o_rd_n || o_wr_n)
    else $error("read and write strobes together");
endmodule // cms_core_assertions

bind cms_core cms_core_assertions #(.MC_CLKS(MC_CLKS)) chk_u (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_low_port_bus(i_low_port_bus),
  .o_low_port_bus(o_low_port_bus), .o_low_port_oe(o_low_port_oe),
  .o_high_port_bus(o_high_port_bus), .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
  .o_instr_done(o_instr_done), .o_acc(o_acc));

// *** dv/cms_xmem_model.sv ***
// external data memory on the multiplexed low and high port buses
`timescale 1ns/100ps
module cms_xmem_model (
  input wire logic i_core_clk,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_low_bus,
  input wire logic [7:0] i_high_bus,
  output logic [7:0] o_data,
  output logic o_drive
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_ff;
  always @(posedge i_core_clk) begin
    if (i_ale)
      addr_ff <= {i_high_bus, i_low_bus};
    if (!i_wr_n)
      mem[addr_ff] <= i_low_bus;
  end
  // answers at once, but only while the read strobe is low
  assign o_drive = !i_rd_n;
  assign o_data = mem[addr_ff];
endmodule // cms_xmem_model

// *** dv/tb.sv ***
// self-checking bench: program image, shadow state and scoreboard
`timescale 1ns/100ps
module tb;
  logic i_core_clk;
  logic i_sys_rst;
  logic [7:0] rom [0:65535];
  wire [15:0] o_code_addr, o_program_counter, o_data_pointer;
  wire [7:0] o_low_port_bus, o_high_port_bus, o_acc, o_mul_reg, o_psw, mem_data;
  wire o_low_port_oe, o_ale, o_rd_n, o_wr_n, o_instr_done, o_illegal, mem_drive;
  wire [7:0] i_low_port_bus, i_code_data;
  logic [7:0] pin_last_ff, sacc, sb, spsw, r, v;
  logic [15:0] sdp, prod;
  logic [55:0] exp_q[$];
  logic [55:0] exp_v;
  int prog_ptr, err_count, checks_done, i, ill_seen;
  assign i_code_data = rom[o_code_addr];
  // released pins show the inverted last value so a missed strobe cannot pass
  always @(posedge i_core_clk) if (o_low_port_oe) pin_last_ff <= o_low_port_bus;
  assign i_low_port_bus = o_low_port_oe ? o_low_port_bus : (mem_drive ? mem_data : ~pin_last_ff);
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  cms_core #(.MC_CLKS(6), .RAM_DEPTH(256)) dut_u (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .o_code_addr(o_code_addr), .i_code_data(i_code_data),
    .o_low_port_bus(o_low_port_bus), .o_low_port_oe(o_low_port_oe),
    .i_low_port_bus(i_low_port_bus), .o_high_port_bus(o_high_port_bus), .o_ale(o_ale),
    .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_instr_done(o_instr_done), .o_illegal(o_illegal),
    .o_program_counter(o_program_counter), .o_acc(o_acc), .o_mul_reg(o_mul_reg),
    .o_psw(o_psw), .o_data_pointer(o_data_pointer));
  cms_xmem_model xmem_u (.i_core_clk(i_core_clk), .i_ale(o_ale), .i_rd_n(o_rd_n),
    .i_wr_n(o_wr_n), .i_low_bus(o_low_port_bus), .i_high_bus(o_high_port_bus),
    .o_data(mem_data), .o_drive(mem_drive));
  task automatic put(input int n, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
                     input logic [7:0] b2 = 8'h00);
    rom[prog_ptr] = b0;
    rom[prog_ptr + 1] = b1;
    rom[prog_ptr + 2] = b2;
    prog_ptr = prog_ptr + n;
    // pc must sit on the next opcode once the instruction ends
    exp_q.push_back({16'(prog_ptr), sacc, sb, spsw & 8'h84, sdp});
  endtask
  task automatic mov_imm(input logic [7:0] d, input logic [7:0] x);
    if (d == 8'hE0) sacc = x;
    if (d == 8'hF0) sb = x;
    put(3, 8'h75, d, x);
  endtask
  task automatic check(input logic [55:0] seen, input logic [55:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // state after each instruction against the oldest note
  always @(negedge i_core_clk) begin
    if (o_instr_done === 1'b1 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      check({o_program_counter, o_acc, o_mul_reg, o_psw & 8'h84, o_data_pointer}, exp_v);
    end
  end
  // one unknown opcode is planted; count its flag pulses
  always @(negedge i_core_clk) begin
    if (o_illegal === 1'b1)
      ill_seen++;
  end
  initial begin
    i_sys_rst = 1'b1;
    pin_last_ff = 8'h00;
    ill_seen = 0;
    void'($urandom(32'h1206327E));
    for (i = 0; i < 65536; i++) rom[i] = (i < 128) ? 8'h00 : 8'(i ^ (i >> 8) ^ 8'h5A);
    sacc = 8'h00; sb = 8'h00; spsw = 8'h00; sdp = 16'h0000; prog_ptr = 0;
    r = 8'($urandom);
    sacc = r | 8'h80;
    put(2, 8'h44, sacc);
    spsw[7] = 1'b1;
    put(2, 8'hA2, 8'hE7);
    mov_imm(8'hF0, 8'($urandom));
    prod = sacc * sb;
    sacc = prod[7:0];
    sb = prod[15:8];
    spsw[7] = 1'b0;
    spsw[2] = |prod[15:8];
    put(1, 8'hA4);
    put(1, 8'h00);
    put(1, 8'hA5);
    sdp = {2'b01, r[5:0], 4'hF, r[3:0]};
    put(3, 8'h90, sdp[15:8], sdp[7:0]);
    mov_imm(8'hE0, 8'h20 | r);
    sacc = rom[sdp + {8'h00, sacc}];
    put(1, 8'h93);
    mov_imm(8'hE0, 8'h80 | r);
    sacc = rom[16'(prog_ptr + 1 + sacc)];
    put(1, 8'h83);
    r = 8'($urandom);
    v = 8'($urandom);
    sdp = {1'b0, r[6:0], v};
    put(3, 8'h90, sdp[15:8], sdp[7:0]);
    mov_imm(8'hE0, v ^ 8'h3C);
    put(1, 8'hF0);
    sacc = 8'hFF;
    put(2, 8'h44, 8'hFF);
    sacc = v ^ 8'h3C;
    put(1, 8'hE0);
    mov_imm(8'h00, r);
    mov_imm(8'hE0, v);
    put(1, 8'hF2);
    sdp = {8'hFF, r};
    put(3, 8'h90, 8'hFF, r);
    mov_imm(8'hE0, 8'h00);
    sacc = v;
    put(1, 8'hE0); // pointer high byte FF shown during pointer access
    mov_imm(8'h01, r);
    mov_imm(8'hE0, 8'h00);
    sacc = v;
    put(1, 8'hE3);
    mov_imm(8'h01, 8'h40);
    r = 8'($urandom);
    put(2, 8'h77, r);
    sacc = r;
    put(2, 8'h87, 8'hE0);
    sacc = r | 8'h81;
    put(2, 8'h44, 8'h81);
    put(1, 8'hF7);
    sb = sacc;
    put(2, 8'h87, 8'hF0);
    v = 8'($urandom);
    mov_imm(8'h30, v);
    put(2, 8'hA7, 8'h30);
    sb = v;
    put(2, 8'h87, 8'hF0);
    r = 8'($urandom);
    put(3, 8'h43, 8'h30, r);
    mov_imm(8'hE0, 8'h00);
    sacc = v | r;
    put(2, 8'h45, 8'h30);
    r = 8'($urandom);
    mov_imm(8'h03, r);
    sacc = sacc | r;
    put(1, 8'h4B);
    sacc = sacc | v;
    put(1, 8'h47);
    sb = sb | sacc;
    put(2, 8'h42, 8'hF0);
    sacc = sacc | 8'h80;
    put(2, 8'h44, 8'h80);
    spsw[7] = 1'b1;
    put(2, 8'hA2, 8'hE7);
    sb[0] = 1'b1;
    put(2, 8'h92, 8'hF0);
    r = 8'($urandom);
    v = 8'($urandom);
    mov_imm(8'h80, r);
    put(3, 8'h43, 8'h80, v);
    mov_imm(8'hE0, 8'h00);
    sacc = r | v;
    put(2, 8'h45, 8'h80);
    repeat (20) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    for (i = 0; i < 20000 && exp_q.size() > 0; i++) @(negedge i_core_clk);
    if (exp_q.size() > 0) err_count++;
    check(56'(ill_seen), 56'h1);
    test_done;
  end
endmodule // tb
